// ### hw/scss_defs.svh
/*
 Constants for the system clock source select block: mode codes, field
 resets and switch timing. Assumes inclusion by bare name from hw/.
*/
`ifndef SCSS_DEFS_SVH
`define SCSS_DEFS_SVH

// ==========================================================
// Oscillator mode codes (configuration fuse field)
`define SCSS_MODE_RC          4'h0
`define SCSS_MODE_RC_IO       4'h1
`define SCSS_MODE_EXTCLK      4'h2
`define SCSS_MODE_EXTCLK_X4   4'h3
`define SCSS_MODE_XTAL        4'h4
`define SCSS_MODE_XTAL_X4     4'h5
`define SCSS_MODE_INT_CLKOUT  4'h6
`define SCSS_MODE_INT_DUALIO  4'h7

// ==========================================================
// Reset values and field codes
`define SCSS_POSTSCALER_RST   3'h6
`define SCSS_POSTSCALER_16M   3'h7
`define SCSS_SYSSEL_RST       2'h0
`define SCSS_SYSSEL_PRIMARY   2'h0
`define SCSS_SYSSEL_SECONDARY 2'h1

// ==========================================================
// Clock switch pause: two old cycles plus four new cycles; divide-by-four toggle point
`define SCSS_OLD_CYCLES       3'h2
`define SCSS_NEW_CYCLES       3'h4
`define SCSS_DIV4_HALF        1'h1

`endif

// ### hw/scss_pkg.sv
/*
 Types for the system clock source select block.
 Assumes scss_defs.svh is compiled alongside.
*/
package scss_pkg;
   typedef enum logic [1:0] {
      SCSS_RUN      = 2'b00,
      SCSS_DRAIN    = 2'b01,
      SCSS_SETTLE   = 2'b10
   } scss_state_t;

   typedef enum logic [1:0] {
      SCSS_SRC_PRIMARY = 2'b00,
      SCSS_SRC_HF      = 2'b01,
      SCSS_SRC_MF      = 2'b10,
      SCSS_SRC_LF      = 2'b11
   } scss_src_t;
endpackage : scss_pkg

// ### hw/scss_edge_count.sv
/*
 Counts rising edges of a sampled clock level and flags when a target
 count is reached. Assumes the level is synchronous to sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module scss_edge_count (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       start,
   input  wire logic       clk_level,
   input  wire logic [2:0] target,
   output logic            done
);
   logic       prev_reg;
   logic [2:0] cnt_reg;

   // ==========================================================
   // Edge counter
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= clk_level;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || start) begin
         cnt_reg <= 3'h0;
      end else if (clk_level && !prev_reg && cnt_reg != target) begin
         cnt_reg <= cnt_reg + 3'h1;
      end
   end

   assign done = (cnt_reg == target) && !start;
endmodule : scss_edge_count
`default_nettype wire

// ### hw/scss_top.sv
/*
 System clock source select: chooses the device clock source, gates it
 low across switches, cutting short any high phase in progress, drives the oscillator pins and enables.
 Assumes every source clock arrives as a level sampled on sys_clk, which
 must be much faster than any source it watches.
*/
`timescale 1ns/10ps
`default_nettype none
`include "scss_defs.svh"

module scss_top
   import scss_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic [3:0] osc_mode_fuse,
   input  wire logic       multiplier_fuse_enable,
   input  wire logic       multiplier_sw_enable,
   input  wire logic       low_freq_source_select,
   input  wire logic       medium_source_select,
   input  wire logic [2:0] internal_postscaler_select_in,
   input  wire logic       internal_postscaler_write,
   input  wire logic [1:0] system_clock_select_in,
   input  wire logic       system_clock_select_write,
   input  wire logic       powerup_timer_enable,
   input  wire logic       failsafe_monitor_enable,
   input  wire logic       watchdog_enable,
   input  wire logic       two_speed_enable,
   input  wire logic       primary_clk_level,
   input  wire logic       secondary_clk_level,
   input  wire logic       high_freq_internal_source,
   input  wire logic       medium_freq_internal_source,
   input  wire logic       low_freq_rc_source,
   input  wire logic       multiplier_clk_level,
   input  wire logic       osc_in_pin_in,
   input  wire logic       osc_out_pin_in,
   input  wire logic       port_a_bit6_out,
   input  wire logic       port_a_bit6_oe,
   input  wire logic       port_a_bit7_out,
   input  wire logic       port_a_bit7_oe,
   output logic            osc_in_pin_out,
   output logic            osc_in_pin_oe,
   output logic            osc_out_pin_out,
   output logic            osc_out_pin_oe,
   output logic            port_a_bit6_in,
   output logic            port_a_bit7_in,
   output logic            sys_clk_gated,
   output logic            clock_switching,
   output logic            startup_wait_needed,
   output logic            multiplier_active,
   output logic            low_freq_rc_enable,
   output logic [2:0]      internal_postscaler_select,
   output logic [1:0]      system_clock_select,
   output logic [1:0]      active_source
);
   scss_state_t state_reg;
   scss_src_t   cur_src_reg;
   scss_src_t   new_src_reg;
   scss_src_t   want_src;
   logic [2:0]  postscaler_reg;
   logic [1:0]  clk_sel_reg;
   logic [1:0]  div_reg;
   logic        div_out_reg;
   logic        gate_reg;
   logic        osc_in_oe_reg;
   logic        osc_out_oe_reg;
   logic        osc_out_val_reg;
   logic        rx6_reg;
   logic        rx7_reg;
   logic        cur_level;
   logic        new_level;
   logic        prev_cur_reg;
   logic        old_done;
   logic        new_done;
   logic        start_pulse;
   logic        mode_ext_clock;
   logic        mode_x4;
   logic        mode_internal;
   logic        mode_rc;
   logic        div4_enable;
   logic        primary_level;
   logic        low_range;

   // ==========================================================
   // Mode decode
   always_comb begin
      mode_ext_clock = (osc_mode_fuse == `SCSS_MODE_EXTCLK)
                    || (osc_mode_fuse == `SCSS_MODE_EXTCLK_X4);
      mode_internal  = (osc_mode_fuse == `SCSS_MODE_INT_CLKOUT)
                    || (osc_mode_fuse == `SCSS_MODE_INT_DUALIO);
      mode_rc        = (osc_mode_fuse == `SCSS_MODE_RC)
                    || (osc_mode_fuse == `SCSS_MODE_RC_IO);
      // Multiplier modes still need an enable; the internal path also needs postscaler code 110 or 111, external input range is left to software
      mode_x4        = (((osc_mode_fuse == `SCSS_MODE_XTAL_X4)
                    || (osc_mode_fuse == `SCSS_MODE_EXTCLK_X4))
                        && (multiplier_sw_enable || multiplier_fuse_enable))
                    || (multiplier_sw_enable && mode_internal
                        && postscaler_reg[2:1] == 2'b11);
   end

   assign multiplier_active   = mode_x4;
   assign startup_wait_needed = !(mode_ext_clock || mode_rc);

   // ==========================================================
   // Internal block frequency selection
   // Postscaler codes 000 pick the low range; the rest pick the HF tap
   assign low_range = (postscaler_reg == 3'h0);

   always_comb begin
      if (!low_range) begin
         want_src = SCSS_SRC_HF;
      end else if (low_freq_source_select && !medium_source_select) begin
         want_src = SCSS_SRC_HF;
      end else if (low_freq_source_select) begin
         want_src = SCSS_SRC_MF;
      end else begin
         want_src = SCSS_SRC_LF;
      end
      if (clk_sel_reg == `SCSS_SYSSEL_PRIMARY && !mode_internal) begin
         want_src = SCSS_SRC_PRIMARY;
      end
   end

   always_comb begin
      primary_level = mode_x4 ? multiplier_clk_level : primary_clk_level;
      // Select 01 swaps the level seen on the primary path
      if (clk_sel_reg == `SCSS_SYSSEL_SECONDARY) begin
         primary_level = secondary_clk_level;
      end
   end

   function automatic logic level_of(input scss_src_t s, input logic p,
                                     input logic hf, input logic mf,
                                     input logic lf);
      case (s)
         SCSS_SRC_PRIMARY: level_of = p;
         SCSS_SRC_HF:      level_of = hf;
         SCSS_SRC_MF:      level_of = mf;
         default:          level_of = lf;
      endcase
   endfunction : level_of

   assign cur_level = level_of(cur_src_reg, primary_level, high_freq_internal_source,
                               medium_freq_internal_source, low_freq_rc_source);
   assign new_level = level_of(new_src_reg, primary_level, high_freq_internal_source,
                               medium_freq_internal_source, low_freq_rc_source);

   assign low_freq_rc_enable = (cur_src_reg == SCSS_SRC_LF)
                            || (new_src_reg == SCSS_SRC_LF)
                            || powerup_timer_enable || failsafe_monitor_enable
                            || watchdog_enable || two_speed_enable;

   // ==========================================================
   // Software control fields
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         postscaler_reg <= `SCSS_POSTSCALER_RST;
      end else if (internal_postscaler_write) begin
         postscaler_reg <= internal_postscaler_select_in;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         clk_sel_reg <= `SCSS_SYSSEL_RST;
      end else if (system_clock_select_write) begin
         clk_sel_reg <= system_clock_select_in;
      end
   end

   // Fields show the new value after the write edge; a switch starts one edge later
   assign internal_postscaler_select = postscaler_reg;
   assign system_clock_select        = clk_sel_reg;

   // ==========================================================
   // Hold-low switch sequencer
   // Clock is held low: drain two old edges, then count new edges
   assign start_pulse = (state_reg == SCSS_RUN) && (want_src != cur_src_reg);

   scss_edge_count u_old_count (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .start     (start_pulse),
      .clk_level (cur_level),
      .target    (`SCSS_OLD_CYCLES),
      .done      (old_done)
   );

   scss_edge_count u_new_count (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .start     (start_pulse || state_reg != SCSS_SETTLE),
      .clk_level (new_level),
      .target    (`SCSS_NEW_CYCLES),
      .done      (new_done)
   );

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg   <= SCSS_RUN;
         cur_src_reg <= SCSS_SRC_PRIMARY;
         new_src_reg <= SCSS_SRC_PRIMARY;
      end else begin
         case (state_reg)
            SCSS_RUN: begin
               if (start_pulse) begin
                  new_src_reg <= want_src;
                  state_reg   <= SCSS_DRAIN;
               end
            end
            SCSS_DRAIN: begin
               if (old_done) begin
                  state_reg <= SCSS_SETTLE;
               end
            end
            SCSS_SETTLE: begin
               if (new_done) begin
                  cur_src_reg <= new_src_reg;
                  state_reg   <= SCSS_RUN;
               end
            end
            default: state_reg <= SCSS_RUN;
         endcase
      end
   end

   assign clock_switching = (state_reg != SCSS_RUN);
   assign active_source   = cur_src_reg;

   // Follow the current clock in RUN; force low as soon as a switch starts, even while the current clock is high
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         gate_reg <= 1'b0;
      end else begin
         gate_reg <= (state_reg == SCSS_RUN) && !start_pulse && cur_level;
      end
   end

   assign sys_clk_gated = gate_reg;

   // ==========================================================
   // Divide-by-four output
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prev_cur_reg <= 1'b0;
      end else begin
         prev_cur_reg <= gate_reg;
      end
   end

   // Counts gated clock edges; output toggles every two, near 50 percent
   always_ff @(posedge sys_clk) begin
      if (rst || clock_switching) begin
         div_reg     <= 2'h0;
         div_out_reg <= 1'b0;
      end else if (gate_reg && !prev_cur_reg) begin
         div_reg <= div_reg + 2'h1;
         if (div_reg[0] == `SCSS_DIV4_HALF) begin
            div_out_reg <= !div_out_reg;
         end
      end
   end

   // ==========================================================
   // Oscillator pin ownership
   always_comb begin
      div4_enable = (osc_mode_fuse == `SCSS_MODE_RC)
                 || (osc_mode_fuse == `SCSS_MODE_EXTCLK)
                 || (osc_mode_fuse == `SCSS_MODE_INT_CLKOUT);
      // High-speed and multiplier modes keep the pin for the crystal
      if (osc_mode_fuse == `SCSS_MODE_XTAL) begin
         div4_enable = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         osc_out_oe_reg  <= 1'b0;
         osc_out_val_reg <= 1'b0;
         osc_in_oe_reg   <= 1'b0;
      end else begin
         if (div4_enable) begin
            osc_out_oe_reg  <= 1'b1;
            osc_out_val_reg <= div_out_reg;
         end else if (osc_mode_fuse == `SCSS_MODE_RC_IO
                   || osc_mode_fuse == `SCSS_MODE_INT_DUALIO) begin
            osc_out_oe_reg  <= port_a_bit6_oe;
            osc_out_val_reg <= port_a_bit6_out;
         end else begin
            osc_out_oe_reg  <= 1'b0;
            osc_out_val_reg <= 1'b0;
         end
         if (mode_internal) begin
            osc_in_oe_reg <= port_a_bit7_oe;
         end else begin
            osc_in_oe_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rx6_reg <= 1'b0;
         rx7_reg <= 1'b0;
      end else begin
         rx6_reg <= (osc_mode_fuse == `SCSS_MODE_RC_IO
                  || osc_mode_fuse == `SCSS_MODE_INT_DUALIO) && osc_out_pin_in;
         rx7_reg <= mode_internal && osc_in_pin_in;
      end
   end

   assign osc_out_pin_out = osc_out_val_reg;
   assign osc_out_pin_oe  = osc_out_oe_reg;
   assign osc_in_pin_out  = osc_in_oe_reg && port_a_bit7_out;
   assign osc_in_pin_oe   = osc_in_oe_reg;
   assign port_a_bit6_in  = rx6_reg;
   assign port_a_bit7_in  = rx7_reg;
endmodule : scss_top
`default_nettype wire

// ### sim/scss_top_checker.sv
/*
 Port checker for scss_top: reset values, pin modes, multiplier enable
 and clock switch pause. Assumes scss_defs.svh on the include path.
*/
`timescale 1ns/10ps
`default_nettype none
`include "scss_defs.svh"
module scss_top_checker (
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic [3:0] osc_mode_fuse,
   input wire logic       multiplier_fuse_enable,
   input wire logic       multiplier_sw_enable,
   input wire logic [2:0] internal_postscaler_select_in,
   input wire logic       internal_postscaler_write,
   input wire logic       powerup_timer_enable,
   input wire logic       failsafe_monitor_enable,
   input wire logic       watchdog_enable,
   input wire logic       two_speed_enable,
   input wire logic       osc_out_pin_oe,
   input wire logic       sys_clk_gated,
   input wire logic       clock_switching,
   input wire logic       startup_wait_needed,
   input wire logic       multiplier_active,
   input wire logic       low_freq_rc_enable,
   input wire logic [2:0] internal_postscaler_select,
   input wire logic [1:0] system_clock_select
);
   // ==========================================================
   // Assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Reset checks may not be disabled by the reset that causes them
   a_rst_scaler: assert property (disable iff (1'b0) $fell(rst) |->
      internal_postscaler_select == `SCSS_POSTSCALER_RST) else $error("postscaler reset");
   a_rst_select: assert property (disable iff (1'b0) $fell(rst) |->
      system_clock_select == `SCSS_SYSSEL_RST && !clock_switching) else $error("select reset");
   a_ext_nowait: assert property (osc_mode_fuse inside
      {`SCSS_MODE_EXTCLK, `SCSS_MODE_EXTCLK_X4} |-> !startup_wait_needed)
      else $error("start-up wait in external clock mode");
   a_x4_on: assert property ((multiplier_sw_enable || multiplier_fuse_enable) &&
      osc_mode_fuse inside {`SCSS_MODE_EXTCLK_X4, `SCSS_MODE_XTAL_X4} |-> multiplier_active)
      else $error("multiplier not active");
   a_lf_needed: assert property (powerup_timer_enable || failsafe_monitor_enable ||
      watchdog_enable || two_speed_enable |-> low_freq_rc_enable) else $error("low rc off");
   a_xtal_no_out: assert property ((osc_mode_fuse == `SCSS_MODE_XTAL) [*2]
      |-> !osc_out_pin_oe) else $error("clock out driven in crystal mode");
   a_rc_out: assert property ((osc_mode_fuse == `SCSS_MODE_RC) [*3]
      |-> osc_out_pin_oe) else $error("clock out missing in rc mode");
   a_switch_len: assert property ($rose(clock_switching) |->
      clock_switching [*4] ##[1:400] !clock_switching) else $error("switch pause length");
   a_gate_hold: assert property (clock_switching ##1 clock_switching
      |-> !sys_clk_gated) else $error("clock ran during switch");
   a_scaler_load: assert property (internal_postscaler_write |=>
      internal_postscaler_select == $past(internal_postscaler_select_in))
      else $error("postscaler not loaded");
endmodule : scss_top_checker

bind scss_top scss_top_checker scss_top_checker_inst (
   .sys_clk, .rst, .osc_mode_fuse, .multiplier_fuse_enable, .multiplier_sw_enable,
   .internal_postscaler_select_in, .internal_postscaler_write, .powerup_timer_enable,
   .failsafe_monitor_enable, .watchdog_enable, .two_speed_enable, .osc_out_pin_oe,
   .sys_clk_gated, .clock_switching, .startup_wait_needed, .multiplier_active,
   .low_freq_rc_enable, .internal_postscaler_select, .system_clock_select
);
`default_nettype wire

// ### sim/scss_osc_model.sv
/*
 Free-running oscillator sources as levels sampled on sys_clk.
 Assumes sys_clk at 250 MHz; periods are whole sys_clk cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module scss_osc_model (
   input  wire logic sys_clk,
   output logic      primary_clk_level,
   output logic      secondary_clk_level,
   output logic      high_freq_internal_source,
   output logic      medium_freq_internal_source,
   output logic      low_freq_rc_source,
   output logic      multiplier_clk_level
);
   // ==========================================================
   // Sources
   logic [5:0] cnt_reg = 6'h00;
   always_ff @(posedge sys_clk) begin
      cnt_reg <= cnt_reg + 6'h01;
   end
   assign primary_clk_level           = cnt_reg[3];
   assign multiplier_clk_level        = cnt_reg[1];
   assign high_freq_internal_source   = cnt_reg[2];
   assign secondary_clk_level         = cnt_reg[4];
   assign medium_freq_internal_source = ~cnt_reg[4];
   assign low_freq_rc_source          = cnt_reg[5];
endmodule : scss_osc_model
`default_nettype wire

// ### sim/test_system_clock_source_select.sv
/*
 Self-checking bench for scss_top with the oscillator model.
 Assumes scss_defs.svh on the include path and the checker bound.
*/
`timescale 1ns/10ps
`default_nettype none
`include "scss_defs.svh"
module test_system_clock_source_select;
   import scss_pkg::*;
   logic sys_clk, rst, multiplier_fuse_enable, multiplier_sw_enable, ext6;
   logic low_freq_source_select, medium_source_select, internal_postscaler_write;
   logic system_clock_select_write, powerup_timer_enable, failsafe_monitor_enable;
   logic watchdog_enable, two_speed_enable, primary_clk_level, secondary_clk_level;
   logic high_freq_internal_source, medium_freq_internal_source, low_freq_rc_source;
   logic multiplier_clk_level, osc_in_pin_in, osc_out_pin_in, port_a_bit6_out;
   logic port_a_bit6_oe, port_a_bit7_out, port_a_bit7_oe, osc_in_pin_out, osc_in_pin_oe;
   logic osc_out_pin_out, osc_out_pin_oe, port_a_bit6_in, port_a_bit7_in, sys_clk_gated;
   logic clock_switching, startup_wait_needed, multiplier_active, low_freq_rc_enable;
   logic [3:0] osc_mode_fuse;
   logic [2:0] internal_postscaler_select_in, internal_postscaler_select;
   logic [1:0] system_clock_select_in, system_clock_select, active_source;
   int         miscompares = 0, tests_run = 0, n;
   // Pin levels: the design wins when it drives, else the outside world
   assign osc_in_pin_in  = osc_in_pin_oe ? osc_in_pin_out : primary_clk_level;
   assign osc_out_pin_in = osc_out_pin_oe ? osc_out_pin_out : ext6;
   scss_top scss_top_inst (.*);
   scss_osc_model scss_osc_model_inst (.sys_clk, .primary_clk_level, .secondary_clk_level,
      .high_freq_internal_source, .medium_freq_internal_source, .low_freq_rc_source,
      .multiplier_clk_level);
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // ==========================================================
   // Tasks
   task automatic step(input int k);
      repeat (k) @(posedge sys_clk);
   endtask : step
   task automatic look;
      @(negedge sys_clk);
   endtask : look
   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input bit sel, input logic [2:0] v);
      step(1);
      if (sel) begin
         system_clock_select_in <= v[1:0];
         system_clock_select_write <= 1'b1;
      end else begin
         internal_postscaler_select_in <= v;
         internal_postscaler_write <= 1'b1;
      end
      step(1);
      system_clock_select_write <= 1'b0;
      internal_postscaler_write <= 1'b0;
   endtask : wr
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   // Bounded wait until the pause has been over for two looks, since a queued
   // switch may start one cycle after the last one ends; c counts paused looks
   task automatic settle(output int c);
      int q;
      c = 0;
      q = 0;
      step(2);
      while (q < 2 && c < 400) begin
         look;
         q = (clock_switching === 1'b0) ? q + 1 : 0;
         c += int'(q == 0);
      end
      if (q < 2) begin
         miscompares++;
         $display("mismatch at %0t: switch never ended", $time);
         wrap_up;
      end
   endtask : settle
   task automatic div4(input logic [3:0] m);
      int g = 0, o = 0, h = 0;
      logic pg, po;
      step(1);
      osc_mode_fuse <= m;
      settle(n);
      pg = sys_clk_gated;
      po = osc_out_pin_out;
      repeat (512) begin
         look;
         g += int'(sys_clk_gated && !pg);
         o += int'(osc_out_pin_out && !po);
         h += int'(osc_out_pin_out);
         pg = sys_clk_gated;
         po = osc_out_pin_out;
      end
      chk(o * 4 + 4 >= g && o * 4 <= g + 4 && g > 16, 1'b1);
      chk(h >= 192 && h <= 320, 1'b1);
   endtask : div4
   task automatic src(input logic lo, input logic md, input logic [2:0] ps,
                      input logic [1:0] e);
      step(1);
      low_freq_source_select <= lo;
      medium_source_select <= md;
      wr(1'b0, ps);
      settle(n);
      chk(active_source, e);
   endtask : src
   // ==========================================================
   // Main sequence
   initial begin
      rst = 1'b1;
      osc_mode_fuse = `SCSS_MODE_EXTCLK;
      {multiplier_fuse_enable, multiplier_sw_enable, ext6} = 3'h0;
      {low_freq_source_select, medium_source_select, internal_postscaler_write} = 3'h0;
      {powerup_timer_enable, failsafe_monitor_enable, watchdog_enable} = 3'h0;
      {two_speed_enable, system_clock_select_write, port_a_bit6_out} = 3'h0;
      {port_a_bit6_oe, port_a_bit7_out, port_a_bit7_oe} = 3'h3;
      internal_postscaler_select_in = 3'h0;
      system_clock_select_in = 2'h0;
      step(2);
      rst <= 1'b0;
      look;
      chk(internal_postscaler_select, `SCSS_POSTSCALER_RST);
      chk({system_clock_select, active_source}, 4'h0);
      $display("reset test done");
      for (int m = 0; m < 8; m++) begin
         step(1);
         osc_mode_fuse <= m[3:0];
         step(4);
         look;
         if (m != 3) chk(osc_out_pin_oe, 8'b0100_0101 >> m & 1);
         if (m < 6) chk(startup_wait_needed, m[2]);
         chk({osc_in_pin_oe, osc_in_pin_out & osc_in_pin_oe}, {2{m >= 6}});
      end
      for (int m = 1; m < 8; m += 6) begin
         step(1);
         {osc_mode_fuse, port_a_bit6_oe, ext6} <= {m[3:0], 2'h3};
         step(4);
         look;
         chk({osc_out_pin_oe, osc_out_pin_out, port_a_bit6_in}, 3'h4);
         chk(port_a_bit7_in, m == 7);
         step(1);
         port_a_bit6_oe <= 1'b0;
         step(4);
         look;
         chk({osc_out_pin_oe, port_a_bit6_in}, 2'h1);
      end
      $display("pin mode test done");
      div4(`SCSS_MODE_RC);
      div4(`SCSS_MODE_EXTCLK);
      div4(`SCSS_MODE_INT_CLKOUT);
      $display("clock out test done");
      for (int i = 0; i < 4; i++) begin
         step(1);
         {osc_mode_fuse, multiplier_sw_enable, multiplier_fuse_enable} <= {4'h5, i[1:0]};
         look;
         chk(multiplier_active, i != 0);
      end
      step(1);
      {osc_mode_fuse, multiplier_sw_enable, multiplier_fuse_enable} <= 6'h1a;
      look;
      chk(multiplier_active, 1'b1);
      wr(1'b0, 3'h0);
      look;
      chk(multiplier_active, 1'b0);
      step(1);
      {osc_mode_fuse, multiplier_sw_enable} <= {`SCSS_MODE_EXTCLK, 1'b0};
      for (int i = 0; i < 5; i++) begin
         step(1);
         {powerup_timer_enable, failsafe_monitor_enable, watchdog_enable,
          two_speed_enable} <= 4'h1 << i;
         look;
         chk(low_freq_rc_enable, i < 4);
      end
      $display("multiplier and low rc test done");
      settle(n);
      wr(1'b1, 3'h1);
      settle(n);
      chk(n >= 220 && n <= 330, 1'b1);
      chk(active_source, 2'h3);
      wr(1'b1, 3'h2);
      settle(n);
      src(1'b0, 1'b0, 3'h6, 2'h1);
      src(1'b0, 1'b0, 3'h0, 2'h3);
      chk(low_freq_rc_enable, 1'b1);
      src(1'b1, 1'b0, 3'h0, 2'h1);
      src(1'b1, 1'b1, 3'h0, 2'h2);
      wr(1'b1, 3'h0);
      settle(n);
      chk(active_source, 2'h0);
      $display("switch test done");
      wr(1'b0, 3'h7);
      step(1);
      rst <= 1'b1;
      step(2);
      rst <= 1'b0;
      look;
      chk({1'b0, internal_postscaler_select}, 4'h6);
      chk({system_clock_select, active_source}, 4'h0);
      $display("second reset test done");
      wrap_up;
   end
endmodule : test_system_clock_source_select
`default_nettype wire
